// [hw/id_caps_pkg.sv]
// Constants and types shared by the identify capability words block.
// Functional notes
// - Word 64 sets PIO mode 3, 4 bits.
// - Word 65 reports 120 ns minimum DMA cycle.
// - Word 66 reports 120 ns recommended DMA cycle.
// - Faster host DMA cycles may drop the request.
// - Word 67 reports 120 ns PIO cycle.
// - Word 68 reports 120 ns IORDY PIO cycle.
// - Word 80 claims major versions one to six.
// - Word 81 holds minor version 0019H.
// - Word 82 sets bits 14,13,12,6,5,3,1.
// - Word 82 clears all its other bits.
// - Word 83 clears bit 15, sets bit 14.
// - Word 83 sets bits 8, 3, 2.
// - Word 83 clears all remaining bits.
// - Word 84: bit 14 set, rest clear.
package id_caps_pkg;

    localparam int          CLK_PERIOD_PS = 4000;
    localparam int          REC_CYCLE_NS  = 120;
    localparam int          REC_CYCLES    =
        (REC_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    localparam logic [7:0]  W_ADV_PIO   = 8'h40;
    localparam logic [7:0]  W_DMA_MIN   = 8'h41;
    localparam logic [7:0]  W_DMA_REC   = 8'h42;
    localparam logic [7:0]  W_PIO_MIN   = 8'h43;
    localparam logic [7:0]  W_PIO_IORDY = 8'h44;
    localparam logic [7:0]  W_MAJOR     = 8'h50;
    localparam logic [7:0]  W_MINOR     = 8'h51;
    localparam logic [7:0]  W_FEAT0     = 8'h52;
    localparam logic [7:0]  W_FEAT1     = 8'h53;
    localparam logic [7:0]  W_FEAT2     = 8'h54;

    localparam logic [15:0] B0  = 16'h0001;
    localparam logic [15:0] B1  = 16'h0002;
    localparam logic [15:0] B2  = 16'h0004;
    localparam logic [15:0] B3  = 16'h0008;
    localparam logic [15:0] B5  = 16'h0020;
    localparam logic [15:0] B6  = 16'h0040;
    localparam logic [15:0] B8  = 16'h0100;
    localparam logic [15:0] B12 = 16'h1000;
    localparam logic [15:0] B13 = 16'h2000;
    localparam logic [15:0] B14 = 16'h4000;

    localparam logic [15:0] VAL_ADV_PIO = B0 | B1;
    localparam logic [15:0] VAL_CYCLE   = 16'(REC_CYCLE_NS);
    localparam logic [15:0] VAL_MAJOR   = 16'h007E;
    localparam logic [15:0] VAL_MINOR   = 16'h0019;
    localparam logic [15:0] VAL_FEAT0   =
        B14 | B13 | B12 | B6 | B5 | B3 | B1;
    localparam logic [15:0] VAL_FEAT1   = B14 | B8 | B3 | B2;
    localparam logic [15:0] VAL_FEAT2   = B14;

    localparam logic [7:0]  R_CTRL   = 8'h00;
    localparam logic [7:0]  R_STATUS = 8'h04;
    localparam logic [7:0]  R_PERIOD = 8'h08;
    localparam logic [7:0]  R_FASTCT = 8'h0C;
    localparam logic [7:0]  R_IDX    = 8'h10;
    localparam logic [7:0]  R_IDW    = 8'h14;

    localparam int          CTRL_EN_BIT   = 0;
    localparam int          CTRL_HOLD_LSB = 8;
    localparam logic [7:0]  HOLD_RESET    = 8'(REC_CYCLES);
    localparam int          ST_THR_BIT    = 0;
    localparam int          ST_FAST_BIT   = 1;
    localparam int          ST_RQ_BIT     = 2;

    typedef enum logic [0:0] {
        THR_RUN  = 1'b0,
        THR_HOLD = 1'b1
    } thr_state_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    typedef struct packed {
        logic [15:0] period;
        logic        tick;
        logic        fast;
    } cyc_evt_t;

endpackage

// [hw/dma_cycle_mon.sv]
// Host DMA strobe synchroniser and word cycle period monitor.
`timescale 1ns/1ps
`default_nettype none
module dma_cycle_mon
    import id_caps_pkg::*;
#(
    parameter int MIN_CYCLES = REC_CYCLES
) (
    input  wire logic     mclk_i,
    input  wire logic     rst_i,
    input  wire logic     active_i,
    input  wire logic     strobe_pin_i,
    output var cyc_evt_t  evt_o
);

    if (MIN_CYCLES < 1 || MIN_CYCLES > 65535) begin : g_bad_min
        $error("MIN_CYCLES out of range");
    end

    typedef struct packed {
        logic [2:0]  sync;
        logic        level;
        logic        seen;
        logic [15:0] count;
        cyc_evt_t    evt;
    } mon_state_t;

    mon_state_t state_ff;
    mon_state_t nxt_state;
    logic       rise;

    always_comb begin
        nxt_state = state_ff;
        nxt_state.sync = {state_ff.sync[1:0], strobe_pin_i};
        rise = 1'b0;
        // The input counts only once the two later stages agree.
        if (state_ff.sync[2] == state_ff.sync[1]) begin
            nxt_state.level = state_ff.sync[2];
            rise = state_ff.sync[2] & ~state_ff.level;
        end
        if (state_ff.count != 16'hFFFF) begin
            nxt_state.count = state_ff.count + 16'h0001;
        end
        nxt_state.evt.tick = 1'b0;
        nxt_state.evt.fast = 1'b0;
        if (!active_i) begin
            nxt_state.seen = 1'b0;
        end else if (rise) begin
            nxt_state.seen = 1'b1;
            nxt_state.count = 16'h0001;
            nxt_state.evt.tick = state_ff.seen;
            nxt_state.evt.period = state_ff.count;
            nxt_state.evt.fast = state_ff.seen &&
                (state_ff.count < 16'(MIN_CYCLES));
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign evt_o = state_ff.evt;

endmodule // dma_cycle_mon
`default_nettype wire

// [hw/id_caps.sv]
// Identify capability words 64 to 84 with DMA request throttling.
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module id_caps
    import id_caps_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int HOLD_W = 8
) (
    input  wire logic              mclk_i,
    input  wire logic              rst_i,
    input  wire logic              id_rd_i,
    input  wire logic [ADDR_W-1:0] id_addr_i,
    output logic [15:0]            id_data_o,
    output logic                   id_valid_o,
    input  wire logic              dma_req_i,
    input  wire logic              dma_strobe_i,
    output logic                   dmarq_o,
    input  wire reg_req_t          reg_req_i,
    output logic [31:0]            reg_rdata_o
);

    if (ADDR_W != 8) begin : g_bad_addr_w
        $error("ADDR_W must be 8 for a 256 word block");
    end
    if (HOLD_W < 1 || HOLD_W > 8) begin : g_bad_hold_w
        $error("HOLD_W must be 1 to 8");
    end

    typedef struct packed {
        logic [15:0]       id_data;
        logic              id_valid;
        logic              thr_en;
        logic [HOLD_W-1:0] hold;
        thr_state_t        thr;
        logic [HOLD_W-1:0] thr_cnt;
        logic              fast_seen;
        logic [15:0]       fast_cnt;
        logic [15:0]       period;
        logic [ADDR_W-1:0] peek_idx;
        logic              dmarq;
        logic [31:0]       rdata;
    } core_state_t;

    core_state_t state_ff;
    core_state_t nxt_state;
    cyc_evt_t    evt;
    logic        do_throttle;
    logic        fast_clr;
    logic [31:0] status_word;

    dma_cycle_mon #(
        .MIN_CYCLES (REC_CYCLES)
    ) u_mon (
        .mclk_i       (mclk_i),
        .rst_i        (rst_i),
        .active_i     (dma_req_i),
        .strobe_pin_i (dma_strobe_i),
        .evt_o        (evt)
    );

    // All capability words are fixed; nothing here may be altered
    // by software, so the host always sees the same answer.
    function automatic logic [15:0] id_word(
        input logic [ADDR_W-1:0] idx
    );
        logic [15:0] w;
        w = 16'h0000;
        case (idx)
            W_ADV_PIO: begin
                w = VAL_ADV_PIO;
            end
            W_DMA_MIN: begin
                w = VAL_CYCLE;
            end
            W_DMA_REC: begin
                w = VAL_CYCLE;
            end
            W_PIO_MIN: begin
                w = VAL_CYCLE;
            end
            W_PIO_IORDY: begin
                w = VAL_CYCLE;
            end
            W_MAJOR: begin
                w = VAL_MAJOR;
            end
            W_MINOR: begin
                w = VAL_MINOR;
            end
            W_FEAT0: begin
                w = VAL_FEAT0;
            end
            W_FEAT1: begin
                w = VAL_FEAT1;
            end
            W_FEAT2: begin
                w = VAL_FEAT2;
            end
            default: begin
                w = 16'h0000;
            end
        endcase
        return w;
    endfunction

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[ST_THR_BIT]  = (state_ff.thr == THR_HOLD);
        status_word[ST_FAST_BIT] = state_ff.fast_seen;
        status_word[ST_RQ_BIT]   = state_ff.dmarq;
    end

    always_comb begin
        fast_clr = reg_req_i.wr && (reg_req_i.addr == R_STATUS) &&
                   reg_req_i.wdata[ST_FAST_BIT];
        do_throttle = evt.fast && state_ff.thr_en &&
                      (state_ff.thr == THR_RUN);
    end

    always_comb begin
        nxt_state = state_ff;

        // Words are read by index; the answer stands one cycle later.
        nxt_state.id_valid = id_rd_i;
        if (id_rd_i) begin
            nxt_state.id_data = id_word(id_addr_i);
        end

        if (evt.tick) begin
            nxt_state.period = evt.period;
        end

        // A fast cycle in the same cycle as a clear keeps the flag set.
        if (evt.fast) begin
            nxt_state.fast_seen = 1'b1;
            if (state_ff.fast_cnt != 16'hFFFF) begin
                nxt_state.fast_cnt = state_ff.fast_cnt + 16'h0001;
            end
        end else if (fast_clr) begin
            nxt_state.fast_seen = 1'b0;
        end

        case (state_ff.thr)
            THR_RUN: begin
                if (do_throttle) begin
                    nxt_state.thr = THR_HOLD;
                    nxt_state.thr_cnt = state_ff.hold;
                end
            end
            THR_HOLD: begin
                // A zero hold still drops the request for one cycle.
                if (state_ff.thr_cnt <= HOLD_W'(1)) begin
                    nxt_state.thr = THR_RUN;
                    nxt_state.thr_cnt = '0;
                end else begin
                    nxt_state.thr_cnt = state_ff.thr_cnt - HOLD_W'(1);
                end
            end
            default: begin
                nxt_state.thr = THR_RUN;
            end
        endcase

        // The request is dropped the cycle after a fast word cycle.
        nxt_state.dmarq = dma_req_i && !do_throttle &&
                          (nxt_state.thr == THR_RUN);

        if (reg_req_i.wr) begin
            if (reg_req_i.addr == R_CTRL) begin
                nxt_state.thr_en = reg_req_i.wdata[CTRL_EN_BIT];
                nxt_state.hold =
                    reg_req_i.wdata[CTRL_HOLD_LSB +: HOLD_W];
            end else if (reg_req_i.addr == R_FASTCT) begin
                nxt_state.fast_cnt = 16'h0000;
            end else if (reg_req_i.addr == R_IDX) begin
                nxt_state.peek_idx = reg_req_i.wdata[ADDR_W-1:0];
            end
        end

        nxt_state.rdata = 32'h0000_0000;
        if (reg_req_i.rd) begin
            if (reg_req_i.addr == R_CTRL) begin
                nxt_state.rdata[CTRL_EN_BIT] = state_ff.thr_en;
                nxt_state.rdata[CTRL_HOLD_LSB +: HOLD_W] = state_ff.hold;
            end else if (reg_req_i.addr == R_STATUS) begin
                nxt_state.rdata = status_word;
            end else if (reg_req_i.addr == R_PERIOD) begin
                nxt_state.rdata[15:0] = state_ff.period;
            end else if (reg_req_i.addr == R_FASTCT) begin
                nxt_state.rdata[15:0] = state_ff.fast_cnt;
            end else if (reg_req_i.addr == R_IDX) begin
                nxt_state.rdata[ADDR_W-1:0] = state_ff.peek_idx;
            end else if (reg_req_i.addr == R_IDW) begin
                nxt_state.rdata[15:0] = id_word(state_ff.peek_idx);
            end else begin
                nxt_state.rdata = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff          <= '0;
            state_ff.thr_en   <= 1'b1;
            state_ff.hold     <= HOLD_W'(HOLD_RESET);
            state_ff.thr      <= THR_RUN;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign id_data_o   = state_ff.id_data;
    assign id_valid_o  = state_ff.id_valid;
    assign dmarq_o     = state_ff.dmarq;
    assign reg_rdata_o = state_ff.rdata;

endmodule // id_caps
`default_nettype wire

// [verification/host_dma_model.sv]
// Host side model that paces DMA word strobes at a set cycle length.
`timescale 1ns/1ps
`default_nettype none
module host_dma_model (
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    input  wire logic       run_i,
    input  wire logic [7:0] half_i,
    output logic            strobe_o
);
    logic [7:0] cnt_ff;
    // Words keep coming whatever dmarq_o does.
    // Identify words are never read here, so nothing here steers on
    // the DMA cycle words 65 and 66.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_ff <= 8'h00;
            strobe_o <= 1'b0;
        end else if (!run_i) begin
            cnt_ff <= 8'h00;
            strobe_o <= 1'b0;
        end else if (cnt_ff == half_i - 8'h01) begin
            cnt_ff <= 8'h00;
            strobe_o <= !strobe_o;
        end else begin
            cnt_ff <= cnt_ff + 8'h01;
        end
    end
endmodule // host_dma_model
`default_nettype wire

// [verification/id_caps_properties.sv]
// Assertion checker for the identify capability words block.
`timescale 1ns/1ps
`default_nettype none
module id_caps_properties
    import id_caps_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int HOLD_W = 8
) (
    input wire logic              mclk_i,
    input wire logic              rst_i,
    input wire logic              id_rd_i,
    input wire logic [ADDR_W-1:0] id_addr_i,
    input wire logic [15:0]       id_data_o,
    input wire logic              id_valid_o,
    input wire logic              dma_req_i,
    input wire logic              dma_strobe_i,
    input wire logic              dmarq_o,
    input wire reg_req_t          reg_req_i,
    input wire logic [31:0]       reg_rdata_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    sequence rd_at(int a);
        id_rd_i && id_addr_i == a;
    endsequence
    AST_VALID: assert property (
        id_rd_i |=> id_valid_o) else $error("no valid");
    AST_W64: assert property (
        rd_at(64) |=> id_data_o == 16'h0003) else $error("bad w64");
    AST_CYC: assert property (
        id_rd_i && id_addr_i inside {[65:68]} |=> id_data_o == 16'h0078)
        else $error("bad cycle word");
    AST_W80: assert property (
        rd_at(80) |=> id_data_o == 16'h007E) else $error("bad w80");
    AST_W81: assert property (
        rd_at(81) |=> id_data_o == 16'h0019) else $error("bad w81");
    AST_W82: assert property (
        rd_at(82) |=> id_data_o == 16'h706A) else $error("bad w82");
    AST_W83: assert property (
        rd_at(83) |=> id_data_o == 16'h410C) else $error("bad w83");
    AST_W84: assert property (
        rd_at(84) |=> id_data_o == 16'h4000) else $error("bad w84");
    AST_UNMAPPED: assert property (
        id_rd_i && !(id_addr_i inside {[64:68], [80:84]})
        |=> id_data_o == 16'h0000) else $error("bad other word");
    AST_HOLD: assert property (
        !id_rd_i |=> !id_valid_o && $stable(id_data_o))
        else $error("word moved");
    AST_DMARQ: assert property (
        !dma_req_i |=> !dmarq_o) else $error("dmarq without request");
    cover property (rd_at(81));
    cover property (dma_req_i && !dmarq_o);
    cover property (reg_req_i.rd && reg_req_i.addr == 8'h08);
endmodule // id_caps_properties
bind id_caps id_caps_properties #(.ADDR_W(ADDR_W), .HOLD_W(HOLD_W)) i_props (
    .mclk_i(mclk_i), .rst_i(rst_i), .id_rd_i(id_rd_i),
    .id_addr_i(id_addr_i), .id_data_o(id_data_o), .id_valid_o(id_valid_o),
    .dma_req_i(dma_req_i), .dma_strobe_i(dma_strobe_i), .dmarq_o(dmarq_o),
    .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o));
`default_nettype wire

// [verification/id_caps_tb.sv]
// Self-checking bench for the identify capability words block.
`timescale 1ns/1ps
`default_nettype none
module id_caps_tb
    import id_caps_pkg::*;
;
    logic        mclk_i, rst_i, id_rd_i, dma_req_i, strobe, run;
    logic        id_valid_o, dmarq_o;
    logic [7:0]  id_addr_i, half;
    logic [15:0] id_data_o;
    logic [31:0] reg_rdata_o;
    reg_req_t    rq;
    int          fail_count, n_compared, c;
    // Index in the top byte, expected word below; zero words go first.
    logic [23:0] rows [15] = '{
        24'h3F0000, 24'h450000,
        24'h4F0000, 24'h550000,
        24'hFF0000, 24'h400003,
        24'h410078, 24'h420078,
        24'h430078, 24'h440078,
        24'h50007E, 24'h510019,
        24'h52706A,
        24'h53410C,
        24'h544000};
    id_caps i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .id_rd_i(id_rd_i),
        .id_addr_i(id_addr_i), .id_data_o(id_data_o),
        .id_valid_o(id_valid_o), .dma_req_i(dma_req_i),
        .dma_strobe_i(strobe), .dmarq_o(dmarq_o), .reg_req_i(rq),
        .reg_rdata_o(reg_rdata_o));
    host_dma_model i_host (.mclk_i(mclk_i), .rst_i(rst_i), .run_i(run),
        .half_i(half), .strobe_o(strobe));
    task automatic chk(input string n, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        rq <= '{a, d, 1'b1, 1'b0};
        @(posedge mclk_i);
        rq <= '0;
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk_i);
        rq <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge mclk_i);
        rq <= '0;
        #1 chk("reg read", e, reg_rdata_o);
    endtask
    // Counts cycles with dmarq_o low while the request stays up.
    task automatic low_cycles(input int n, output int k);
        k = 0;
        repeat (n) begin
            @(posedge mclk_i);
            #1 k += (dmarq_o !== 1'b1);
        end
    endtask
    task automatic tally_and_finish;
        $display("compared %0d failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end
    // The whole run takes under 1000 cycles.
    initial begin
        #20000;
        fail_count++;
        tally_and_finish();
    end
    initial begin
        rst_i = 1'b1;
        id_rd_i = 1'b0;
        id_addr_i = 8'h00;
        dma_req_i = 1'b0;
        rq = '0;
        run = 1'b0;
        half = 8'h05;
        fail_count = 0;
        n_compared = 0;
        repeat (5) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        #1;
        chk("rst", 32'h0, {id_data_o, id_valid_o, dmarq_o});
        for (int i = 0; i <= 15; i++) begin
            @(posedge mclk_i);
            id_rd_i <= (i < 15);
            id_addr_i <= rows[i % 15][23:16];
            #1;
            if (i > 0) begin
                chk("id word", rows[i-1][15:0], id_data_o);
                chk("id valid", 32'h1, id_valid_o);
            end
        end
        @(posedge mclk_i);
        #1 chk("id hold", 32'h4000, {id_valid_o, id_data_o});
        reg_rd(R_CTRL, 32'h00001E01);
        reg_rd(8'h20, 32'h0);
        reg_wr(R_IDX, 32'h53);
        reg_wr(8'h24, 32'hFF);
        reg_rd(R_IDX, 32'h53);
        reg_rd(R_IDW, 32'h410C);
        @(posedge mclk_i);
        dma_req_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        #1 chk("dmarq up", 32'h1, dmarq_o);
        // A full hold of 30 and the first 21 cycles of the next one.
        @(posedge mclk_i);
        run <= 1'b1;
        low_cycles(80, c);
        chk("fast throttles", 32'h33, c);
        @(posedge mclk_i);
        run <= 1'b0;
        repeat (50) @(posedge mclk_i);
        #1 chk("dmarq back", 32'h1, dmarq_o);
        // Exactly 30 cycles, 120 ns, is not faster than recommended.
        @(posedge mclk_i);
        half <= 8'h0F;
        run <= 1'b1;
        low_cycles(200, c);
        chk("edge rate", 32'h0, c);
        reg_rd(R_PERIOD, 32'h1E);
        @(posedge mclk_i);
        run <= 1'b0;
        half <= 8'h05;
        reg_wr(R_CTRL, 32'h00001E00);
        @(posedge mclk_i);
        run <= 1'b1;
        low_cycles(100, c);
        chk("throttle off", 32'h0, c);
        // Let a fast edge still in the synchroniser land before clearing.
        @(posedge mclk_i);
        run <= 1'b0;
        repeat (10) @(posedge mclk_i);
        reg_rd(R_STATUS, 32'h6);
        reg_wr(R_STATUS, 32'h2);
        reg_rd(R_STATUS, 32'h4);
        reg_wr(R_FASTCT, 32'h0);
        reg_rd(R_FASTCT, 32'h0);
        // A second reset in mid-run must bring back the reset settings.
        @(posedge mclk_i);
        dma_req_i <= 1'b0;
        rst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        #1;
        chk("rst", 32'h0, {id_data_o, id_valid_o, dmarq_o});
        reg_rd(R_CTRL, 32'h00001E01);
        reg_rd(R_IDX, 32'h0);
        reg_rd(R_STATUS, 32'h0);
        tally_and_finish();
    end
endmodule // id_caps_tb
`default_nettype wire
